// ===== pkg/port_ctrl_defs.vh
// Constants for the parallel port control register block.
// Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
// Operation
// - Top two bits written ones, read undefined
// - Direction zero drives data out forward
// - Direction one receives, data drivers released
// - Standard mode: direction write-only, reads zero
// - Extended standard mode: direction read and write
// - EPP: strobes steer direction during cycles
// - ECP: direction readable, no zero-to-one change; the code stores any written direction value
// - FIFO mode: direction write-only, written zero
// - Test FIFO: direction readable, no raising; the code stores any written direction value
// - Interrupt enable bit gates interrupt events
// - Acknowledge release raises interrupt outside DMA
// - EPP timeout flag set raises interrupt
// - Interrupt pin floats when disabled, except ECP
// - Select-in bit one selects the peripheral
// - Outside ECP select-in reads line state
// - In ECP select-in reads stored value
// - EPP timeout flag after ten microseconds
// - All control bits except top two, direction and select-in read back
`ifndef PORT_CTRL_DEFS_VH
`define PORT_CTRL_DEFS_VH

// Register indices; byte address is four times the index
`define STATUS_IDX 8'h01
`define CONTROL_IDX 8'h02
`define MODE_IDX 8'h04

// Control register fields
`define CTL_RSVD_HI 7
`define CTL_RSVD_LO 6
`define CTL_DIR 5
`define CTL_IEN 4
`define CTL_SEL 3
`define CTL_RESET 8'hc0
`define CTL_RSVD_VAL 2'b11

// Status register fields
`define STS_TIMEOUT 0

// Mode register fields and codes
`define MODE_DMA 4
`define MODE_SPP 3'h0
`define MODE_SPP_EXT 3'h1
`define MODE_EPP 3'h2
`define MODE_ECP 3'h3
`define MODE_PP_FIFO 3'h4
`define MODE_TEST_FIFO 3'h5

// Timing
`define CLK_MHZ 200
`define EPP_TIMEOUT_US 10
`define EPP_TIMEOUT_CYC (`EPP_TIMEOUT_US * `CLK_MHZ)

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== src/pin_sync3.v
// Three-stage synchroniser for pin inputs, one stage set per bit.
// A change is accepted only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
	input wire aclk,
	input wire aresetn,
	input wire [WIDTH-1:0] pin,
	output reg [WIDTH-1:0] stable
);
	reg [WIDTH-1:0] s1;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge aclk) begin
				if (!aresetn) begin
					s1[i] <= INIT[i];
					s2[i] <= INIT[i];
					s3[i] <= INIT[i];
					stable[i] <= INIT[i];
				end else begin
					s1[i] <= pin[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						stable[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== src/epp_timeout.v
// Watchdog for one EPP cycle; pulses once when the cycle overruns.
// Counts only while run is high; clearing run rearms it.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defs.vh"
module epp_timeout #(
	parameter CYCLES = `EPP_TIMEOUT_CYC
) (
	input wire aclk,
	input wire aresetn,
	input wire run,
	output reg expired
);
	// Counter is 16 bits; longer limits are cut on purpose
	localparam [31:0] CYCLES_W = CYCLES;
	localparam [15:0] LIMIT = CYCLES_W[15:0];
	reg [15:0] count;
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= 16'h0000;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (!run) begin
				count <= 16'h0000;
			end else if (count != LIMIT) begin
				count <= count + 16'h0001;
				// Full count is at least ten microseconds
				if (count == LIMIT - 16'h0001) begin
					expired <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/port_ctrl_top.v
// Parallel port control register (upper bits), its pins and EPP timeout.
// AXI4-Lite slave on aclk; pins are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defs.vh"
module port_ctrl_top #(
	parameter TIMEOUT_CYCLES = `EPP_TIMEOUT_CYC
) (
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Cable side
	input wire ack_n_pin,
	input wire select_in_line_i,
	output reg select_in_line_o,
	output reg select_in_line_oe_n,
	output reg data_oe_n,
	output reg irq_o,
	output reg irq_oe_n,
	// EPP cycle engine on the same clock
	input wire epp_cycle_active,
	input wire epp_host_write
);
	reg [7:0] port_control;
	reg [2:0] port_mode;
	reg dma_mode;
	reg timeout_flag;

	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire [1:0] pins_stable;
	wire ack_n_s;
	wire sel_line_s;
	reg ack_n_prev;
	wire epp_expired;

	wire mode_spp;
	wire mode_ecp;
	wire mode_epp;
	wire dir_readable;
	wire do_write;
	wire [7:0] w_idx;
	wire [7:0] r_idx;
	wire addr_w_ok;
	wire addr_r_ok;
	wire ack_release;
	wire irq_event;
	wire dir_eff;
	reg [31:0] next_rdata;
	reg next_rok;

	assign ack_n_s = pins_stable[0];
	assign sel_line_s = pins_stable[1];

	pin_sync3 #(
		.WIDTH(2),
		.INIT(2'b11)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({select_in_line_i, ack_n_pin}),
		.stable(pins_stable)
	);

	epp_timeout #(
		.CYCLES(TIMEOUT_CYCLES)
	) u_timeout (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(mode_epp & epp_cycle_active),
		.expired(epp_expired)
	);

	assign mode_spp = (port_mode == `MODE_SPP) || (port_mode == `MODE_PP_FIFO);
	assign mode_ecp = (port_mode == `MODE_ECP);
	assign mode_epp = (port_mode == `MODE_EPP);
	// Write-only direction in plain standard and FIFO modes
	assign dir_readable = !mode_spp;

	// Write path: address and data may arrive in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (!aw_held && s_axi_awvalid && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (!w_held && s_axi_wvalid && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign w_idx = {2'b00, aw_addr[7:2]};
	assign addr_w_ok = (aw_addr[1:0] == 2'b00) &&
		((w_idx == `STATUS_IDX) || (w_idx == `CONTROL_IDX) || (w_idx == `MODE_IDX));

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= addr_w_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register state
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_control <= `CTL_RESET;
			port_mode <= `MODE_SPP;
			dma_mode <= 1'b0;
		end else if (do_write && w_strb[0]) begin
			if (w_idx == `CONTROL_IDX && aw_addr[1:0] == 2'b00) begin
				// All bits stored; software owns bits 7-6 being ones
				port_control <= w_data[7:0];
				// Software keeps the raise legal per mode
			end
			if (w_idx == `MODE_IDX && aw_addr[1:0] == 2'b00) begin
				// Select-in is expected set before this write
				port_mode <= w_data[2:0];
				dma_mode <= w_data[`MODE_DMA];
			end
		end
	end

	// Timeout flag: hardware set beats a same-cycle software clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag <= 1'b0;
		end else if (epp_expired) begin
			timeout_flag <= 1'b1;
		end else if (do_write && w_strb[0] && w_idx == `STATUS_IDX &&
			aw_addr[1:0] == 2'b00 && !w_data[`STS_TIMEOUT]) begin
			timeout_flag <= 1'b0;
		end else if (!mode_epp) begin
			timeout_flag <= 1'b0;
		end
	end

	// Read path: one read at a time, answer two edges after address
	assign r_idx = {2'b00, s_axi_araddr[7:2]};
	assign addr_r_ok = (s_axi_araddr[1:0] == 2'b00) &&
		((r_idx == `STATUS_IDX) || (r_idx == `CONTROL_IDX) || (r_idx == `MODE_IDX));

	always @* begin
		next_rdata = 32'h00000000;
		next_rok = addr_r_ok;
		if (r_idx == `CONTROL_IDX) begin
			next_rdata[`CTL_RSVD_HI:`CTL_RSVD_LO] = `CTL_RSVD_VAL;
			next_rdata[`CTL_DIR] = dir_readable & port_control[`CTL_DIR];
			next_rdata[`CTL_IEN] = port_control[`CTL_IEN];
			// Stored value in ECP, sensed line otherwise
			next_rdata[`CTL_SEL] = mode_ecp ? port_control[`CTL_SEL] : !sel_line_s;
			next_rdata[2:0] = port_control[2:0];
		end else if (r_idx == `STATUS_IDX) begin
			next_rdata[`STS_TIMEOUT] = mode_epp & timeout_flag;
		end else if (r_idx == `MODE_IDX) begin
			next_rdata[2:0] = port_mode;
			next_rdata[`MODE_DMA] = dma_mode;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Direction: EPP strobes win during a cycle
	assign dir_eff = (mode_epp && epp_cycle_active) ? !epp_host_write : port_control[`CTL_DIR];

	// Interrupt sources
	assign ack_release = ack_n_s && !ack_n_prev;
	assign irq_event = port_control[`CTL_IEN] &&
		((ack_release && !dma_mode) || epp_expired);

	always @(posedge aclk) begin
		if (!aresetn) begin
			ack_n_prev <= 1'b1;
			data_oe_n <= 1'b0;
			select_in_line_o <= 1'b1;
			select_in_line_oe_n <= 1'b0;
			irq_o <= 1'b0;
			irq_oe_n <= 1'b1;
		end else begin
			ack_n_prev <= ack_n_s;
			// Released when reversed, driven when forward
			data_oe_n <= dir_eff;
			// Active-low line, low selects the peripheral
			select_in_line_o <= !port_control[`CTL_SEL];
			select_in_line_oe_n <= 1'b0;
			// One-cycle pulse per event on the interrupt pin
			irq_o <= irq_event;
			irq_oe_n <= !mode_ecp && !port_control[`CTL_IEN];
		end
	end
endmodule
`default_nettype wire

// ===== tb/port_ctrl_monitor.sv
// Checker on the top ports of the control register block.
// Assumes EPP cycles are flagged only while the port is in EPP mode.
`timescale 1ns/1ps
`default_nettype none
module port_ctrl_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic select_in_line_o,
	input wire logic select_in_line_oe_n,
	input wire logic irq_o,
	input wire logic irq_oe_n,
	input wire logic data_oe_n,
	input wire logic epp_cycle_active,
	input wire logic epp_host_write
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_sel_driven: assert property (!select_in_line_oe_n) else $error("select-in released");
	// Select-in only follows a completed control write
	chk_sel_on_write: assert property ($changed(select_in_line_o) |-> $past(s_axi_bvalid))
		else $error("select-in moved without a write");
	chk_irq_enabled: assert property (irq_o |-> !irq_oe_n) else $error("irq while floating");
	chk_irq_single: assert property (irq_o |=> !irq_o) else $error("irq pulse too long");
	chk_epp_steer: assert property (epp_cycle_active && $past(epp_cycle_active) && $stable(epp_host_write)
		|-> data_oe_n == !epp_host_write) else $error("epp direction wrong");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
	chk_b_soon: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid) else $error("no bvalid");
	chk_r_soon: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid) else $error("no rvalid");
endmodule
bind port_ctrl_top port_ctrl_monitor mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.select_in_line_o(select_in_line_o),
	.select_in_line_oe_n(select_in_line_oe_n),
	.irq_o(irq_o),
	.irq_oe_n(irq_oe_n),
	.data_oe_n(data_oe_n),
	.epp_cycle_active(epp_cycle_active),
	.epp_host_write(epp_host_write)
);
`default_nettype wire

// ===== tb/printer_model.sv
// Peripheral model: acknowledge pulse of a given length on request.
// Assumes a pull-up on select-in; the peripheral may pull it low.
`timescale 1ns/1ps
`default_nettype none
module printer_model (
	input wire logic aclk,
	input wire logic ack_req,
	input wire logic [3:0] ack_len,
	input wire logic pull,
	input wire logic select_in_line_o,
	input wire logic select_in_line_oe_n,
	output logic ack_n_pin,
	output logic select_in_line_i
);
	logic [3:0] left = 4'h0;
	// Open collector: either side can pull the line low
	assign select_in_line_i = (select_in_line_oe_n | select_in_line_o) & ~pull;
	assign ack_n_pin = (left == 4'h0);
	always @(posedge aclk) begin
		if (ack_req) left <= ack_len;
		else if (left != 4'h0) left <= left - 4'h1;
	end
endmodule
`default_nettype wire

// ===== tb/parallel_port_control_register_tb_top.sv
// Random and corner tests of the control register block over AXI4-Lite.
// Assumes the printer model on the cable and a short EPP timeout.
`timescale 1ns/1ps
`default_nettype none
`include "port_ctrl_defs.vh"
module parallel_port_control_register_tb_top;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, epp_cycle_active = 0, epp_host_write = 0, ack_req = 0, pull = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hf, ack_len = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire ack_n_pin, select_in_line_i, select_in_line_o, select_in_line_oe_n, data_oe_n, irq_o, irq_oe_n;
	int n_fail = 0, check_count = 0;
	localparam logic [7:0] CTL = `CONTROL_IDX << 2, STS = `STATUS_IDX << 2, MOD = `MODE_IDX << 2;
	port_ctrl_top #(.TIMEOUT_CYCLES(8)) dut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ack_n_pin(ack_n_pin),
		.select_in_line_i(select_in_line_i),
		.select_in_line_o(select_in_line_o),
		.select_in_line_oe_n(select_in_line_oe_n),
		.data_oe_n(data_oe_n),
		.irq_o(irq_o),
		.irq_oe_n(irq_oe_n),
		.epp_cycle_active(epp_cycle_active),
		.epp_host_write(epp_host_write)
	);
	printer_model prn (
		.aclk(aclk),
		.ack_req(ack_req),
		.ack_len(ack_len),
		.pull(pull),
		.select_in_line_o(select_in_line_o),
		.select_in_line_oe_n(select_in_line_oe_n),
		.ack_n_pin(ack_n_pin),
		.select_in_line_i(select_in_line_i)
	);
	initial forever #2.5 aclk = ~aclk;
	task automatic summarize;
		$display("Checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic hang(input int i);
		if (i >= 40) begin
			n_fail++;
			summarize();
		end
	endtask
	// Ready is raised late at random so the slave must hold its answer
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i, dl;
		dl = $urandom_range(3, 0);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			s_axi_bready <= (i >= dl);
		end
		hang(i);
		s_axi_bready <= 1'b0;
		cmp({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		int i, dl;
		dl = $urandom_range(3, 0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_rvalid && s_axi_rready) break;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			s_axi_rready <= (i >= dl);
		end
		hang(i);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		cmp({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic pulses(input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge aclk);
			if (irq_o === 1'b1) k++;
		end
	endtask
	function automatic logic [31:0] exp_ctl(input logic [2:0] m, input logic [7:0] c, input logic ln);
		logic [7:0] v;
		v = {2'b11, c[5:0]};
		if (m == `MODE_SPP || m == `MODE_PP_FIFO) v[5] = 1'b0;
		if (m != `MODE_ECP) v[3] = !ln;
		return {24'h0, v};
	endfunction
	initial begin
		logic [31:0] d;
		logic [7:0] c;
		logic [2:0] m;
		logic dma;
		int k;
		void'($urandom(32'h53c0));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		axr(CTL, `RESP_OKAY, d);
		cmp(d, 32'hc0);
		axw(8'h0c, 32'hff, `RESP_SLVERR);
		axr(8'h0c, `RESP_SLVERR, d);
		for (int t = 0; t < 30; t++) begin
			m = 3'($urandom_range(5, 0));
			dma = 1'($urandom_range(1, 0));
			c = {2'b11, 6'($urandom)};
			if (m != `MODE_SPP_EXT) c[5] = 1'b0;
			pull <= 1'($urandom_range(1, 0));
			axw(CTL, 32'hc8, `RESP_OKAY);
			axw(MOD, {27'h0, dma, 1'b0, m}, `RESP_OKAY);
			axw(CTL, {24'h0, c}, `RESP_OKAY);
			// Sensed line needs the pin register and synchroniser to settle
			repeat (6) @(posedge aclk);
			axr(CTL, `RESP_OKAY, d);
			cmp(d, exp_ctl(m, c, !c[3] && !pull));
			cmp({data_oe_n, irq_oe_n, select_in_line_o}, {c[5], m != `MODE_ECP && !c[4], !c[3]});
			ack_len <= 4'($urandom_range(9, 2));
			ack_req <= 1'b1;
			@(posedge aclk);
			ack_req <= 1'b0;
			pulses(30, k);
			cmp(k, {31'h0, c[4] && !dma});
		end
		// Direction left at one from extended mode must still read zero
		axw(MOD, {29'h0, `MODE_SPP_EXT}, `RESP_OKAY);
		axw(CTL, 32'he8, `RESP_OKAY);
		axw(MOD, {29'h0, `MODE_SPP}, `RESP_OKAY);
		axr(CTL, `RESP_OKAY, d);
		cmp(d[5], 1'b0);
		axw(MOD, {29'h0, `MODE_EPP}, `RESP_OKAY);
		axw(CTL, 32'hd0, `RESP_OKAY);
		epp_host_write <= 1'($urandom_range(1, 0));
		epp_cycle_active <= 1'b1;
		pulses(6, k);
		cmp(k, 0);
		pulses(14, k);
		cmp(k, 1);
		cmp(data_oe_n, !epp_host_write);
		axr(STS, `RESP_OKAY, d);
		cmp(d[0], 1'b1);
		epp_cycle_active <= 1'b0;
		axw(STS, 32'h0, `RESP_OKAY);
		axr(STS, `RESP_OKAY, d);
		cmp(d[0], 1'b0);
		summarize();
	end
endmodule
`default_nettype wire
